// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, init, code_ld, bus_intr, byte_op;
    logic byte_odd, ustep_strobe, a_mux_select0, instr_clr, ir_flush, bg_inhibit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, trap_code, code_in, pv_code;
    logic [4:0] raise, flags, clr, pv_f;
    logic [7:0] decode_bits, micro_pc, pv_db;
    logic [15:0] intr_vector, service_vector, pv_iv;
    logic [29:0] ctrl_word;
    logic pv_intr, pv_bo, pv_bd;
    logic [15:0] fv[4] = '{16'h0004, 16'h004c, 16'h0004, 16'h0014};
    logic [15:0] cv[7] = '{16'h0000, 16'h001c, 16'h0018, 16'h0010, 16'h000c, 16'h0008, 16'h0008};
    int n_fail, n_tests, seed, i, exp_pc, pwr;
    int cs[256];
    int ini[6] = '{0, 'h204, 0, 0, 'h110, 'h420};
    assign hready = hreadyout;
    // ====================
    // Clock and instances.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    tsm_trap_sequencer dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .init(init),
        .trap_code(trap_code), .bus_error_flag(flags[0]), .parity_error_flag(flags[1]),
        .stack_ovf_flag(flags[2]), .power_fail_flag(flags[3]), .trace_flag(flags[4]),
        .bus_intr(bus_intr), .intr_vector(intr_vector), .decode_bits(decode_bits),
        .byte_op(byte_op), .byte_odd(byte_odd), .ustep_strobe(ustep_strobe),
        .micro_pc(micro_pc), .ctrl_word(ctrl_word), .a_mux_select0(a_mux_select0),
        .service_vector(service_vector), .trace_clear(clr[4]), .stack_ovf_clear(clr[2]),
        .power_fail_clear(clr[3]), .bus_error_clear(clr[0]), .parity_clear(clr[1]),
        .instr_trap_clear(instr_clr), .ir_flush(ir_flush), .bg_inhibit(bg_inhibit));
    tsm_dp_model dp_u (.clk(clk), .rst(rst), .raise(raise), .clr(clr), .code_in(code_in),
        .code_ld(code_ld), .ir_flush(ir_flush), .flags(flags), .trap_code(trap_code));
    // ====================
    // Tasks: comparison, one AHB-Lite transfer, model of one microstep.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic step_chk();
        int w, nx, k;
        logic [15:0] v;
        logic [5:0] cl;
        logic sel;
        w = cs[exp_pc];
        cl = 6'h00;
        v = 16'h0000;
        sel = 1'b0;
        chk("micro_pc", exp_pc, micro_pc);
        chk("ctrl_word", w, ctrl_word);
        nx = w & 8'hff;
        if (w[8] && pv_bo) nx = nx + (pv_bd ? 3 : 2);
        if (w[10]) nx = nx | pv_db;
        if (w[9]) begin
            for (k = 0; k < 4; k++) if (!sel && pv_f[k]) {sel, cl[k], v} = {2'b11, fv[k]};
            if (!sel && pv_code != 3'h7) {sel, cl[4], v} = {2'b11, cv[pv_code]};
            if (!sel && pv_f[4]) {sel, cl[5], v} = {2'b11, 16'h000c};
            if (!sel && pv_intr) {sel, v} = {1'b1, pv_iv};
            chk("service_vector", v, service_vector);
            chk("clears", cl, {clr[4], instr_clr, clr[3:0]});
        end
        chk("a_mux_select0", sel, a_mux_select0);
        if (sel || pwr) nx = nx | 1;
        pwr = 0;
        exp_pc = nx & 8'hff;
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Reference model: checks every reported microstep against the inputs of its edge.
    always @(posedge clk) begin
        if (!rst && ustep_strobe === 1'b1) step_chk();
        if (rst || init) {exp_pc, pwr} = {32'd0, 32'd1};
        {pv_f, pv_code, pv_intr, pv_iv} = {flags, trap_code, bus_intr, intr_vector};
        {pv_db, pv_bo, pv_bd} = {decode_bits, byte_op, byte_odd};
    end
    // Watchdog against a hung bus or sequencer.
    initial begin
        #125000;
        n_fail++;
        final_report();
    end
    // ====================
    // Main sequence.
    initial begin
        seed = 32'hd6275a35;
        {rst, hsel, hwrite, init, code_ld, bus_intr, byte_op, byte_odd} = 8'hff & 8'h80;
        {haddr, hwdata, htrans, hsize, code_in, raise} = {64'h0, 2'h0, 3'h2, 3'h7, 5'h00};
        {decode_bits, intr_vector} = 24'h000000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        bus(1'b1, 8'h24, 32'hffffffff);
        bus(1'b0, 8'h24, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        bus(1'b1, 8'h04, 32'h0);
        for (i = 0; i < 256; i++) begin
            cs[i] = (i == 8'h7f ? 8'h01 : 8'h7f) | ($random(seed) & 32'h3ffff800);
            if (i < 6) cs[i] = (cs[i] & ~32'h7ff) | ini[i];
            bus(1'b1, 8'h08, cs[i]);
        end
        bus(1'b1, 8'h00, 32'h1);
        for (i = 0; i < 900; i++) begin
            @(posedge clk);
            raise <= 5'($random(seed) & $random(seed) & $random(seed));
            {bus_intr, byte_op, byte_odd} <= 3'($random(seed));
            {intr_vector, decode_bits} <= {16'($random(seed)), 8'($random(seed) & 32'hf)};
            code_ld <= (i % 14 == 0);
            code_in <= (i < 100) ? 3'(i / 14) : 3'($random(seed));
            init <= (i == 500 || i == 501);
        end
        repeat (20) @(posedge clk);
        $display("test microsequencing done");
        final_report();
    end
endmodule

// ---- dv/tsm_dp_model.sv ----
`timescale 1ns/1ps
// ====================
// Datapath and decoder stand-in: holds the trap flags and the trap code.
module tsm_dp_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] raise,
    input wire logic [4:0] clr,
    input wire logic [2:0] code_in,
    input wire logic code_ld,
    input wire logic ir_flush,
    output logic [4:0] flags,
    output logic [2:0] trap_code
);
    // Flags latch on a raise and drop only on reset or when the service logic clears them.
    always @(posedge clk) begin
        if (rst) begin
            flags <= 5'h00;
            trap_code <= 3'h7;
        end else begin
            flags <= (flags & ~clr) | raise;
            if (ir_flush) begin
                trap_code <= 3'h7;
            end else if (code_ld) begin
                trap_code <= code_in;
            end
        end
    end
endmodule

// ---- dv/tsm_trap_sequencer_sva.sv ----
`timescale 1ns/1ps
// ====================
// Service step checks on the top-level ports.
module tsm_trap_sequencer_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] trap_code,
    input wire logic bus_error_flag,
    input wire logic parity_error_flag,
    input wire logic stack_ovf_flag,
    input wire logic power_fail_flag,
    input wire logic trace_flag,
    input wire logic ustep_strobe,
    input wire logic [7:0] micro_pc,
    input wire logic [29:0] ctrl_word,
    input wire logic a_mux_select0,
    input wire logic [15:0] service_vector,
    input wire logic trace_clear,
    input wire logic stack_ovf_clear,
    input wire logic power_fail_clear,
    input wire logic bus_error_clear,
    input wire logic parity_clear,
    input wire logic instr_trap_clear,
    input wire logic ir_flush,
    input wire logic bg_inhibit
);
    logic pend_any;
    logic [5:0] clr_all;
    // Any cause above a bus interrupt, and all clear pulses together.
    assign pend_any = |{bus_error_flag, parity_error_flag, stack_ovf_flag, power_fail_flag,
        trace_flag, trap_code != 3'h7};
    assign clr_all = {trace_clear, stack_ovf_clear, power_fail_clear, bus_error_clear,
        parity_clear, instr_trap_clear};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_svc_branch: assert property (a_mux_select0 ##1 ustep_strobe |-> micro_pc[0])
        else $error("trap branch bit not forced");
    a_svc_word: assert property (a_mux_select0 |-> ustep_strobe && ctrl_word[9])
        else $error("vector select outside service step");
    a_flush_after: assert property (instr_trap_clear |=> ir_flush)
        else $error("flush missing after clear");
    a_flush_cause: assert property (ir_flush |-> $past(instr_trap_clear))
        else $error("flush without clear");
    a_clear_sel: assert property (|clr_all |-> a_mux_select0)
        else $error("clear outside served step");
    a_one_cause: assert property ($onehot0(clr_all))
        else $error("several causes cleared");
    a_vec_buserr: assert property (bus_error_clear |-> service_vector == 16'h0004)
        else $error("bus error vector wrong");
    a_vec_parity: assert property (parity_clear |-> service_vector == 16'h004c)
        else $error("parity vector wrong");
    a_vec_pfail: assert property (power_fail_clear |-> service_vector == 16'h0014)
        else $error("power fail vector wrong");
    a_bg_hold: assert property (!$past(rst) |-> bg_inhibit == $past(pend_any))
        else $error("grant inhibit wrong");
endmodule
bind tsm_trap_sequencer tsm_trap_sequencer_sva chk_u (.*);

// ---- rtl/tsm_arb_if.sv ----
`timescale 1ns/1ps
interface tsm_arb_if;
    logic pend_bus_err;
    logic pend_parity;
    logic pend_stack;
    logic pend_pfail;
    logic pend_trace;
    logic pend_intr;
    logic [2:0] trap_code;
    tsm_pkg::tsm_vector_t intr_vector;
    logic take;
    tsm_pkg::tsm_cause_e cause;
    tsm_pkg::tsm_vector_t vector;
    logic inhibit_bg;

    modport arb (
        input pend_bus_err, pend_parity, pend_stack, pend_pfail, pend_trace, pend_intr,
        input trap_code, intr_vector,
        output take, cause, vector, inhibit_bg
    );
    modport user (
        output pend_bus_err, pend_parity, pend_stack, pend_pfail, pend_trace, pend_intr,
        output trap_code, intr_vector,
        input take, cause, vector, inhibit_bg
    );
endinterface

// ---- rtl/tsm_arbiter.sv ----
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_arbiter (
    tsm_arb_if.arb port
);
    // =================================================================
    // Fixed-priority choice of one pending condition and its vector.
    always_comb begin
        port.take = 1'b1;
        port.cause = tsm_pkg::CAUSE_NONE;
        port.vector = 16'h0000;
        // Only the first hit is served; the rest stay untouched.
        if (port.pend_bus_err) begin
            port.cause = tsm_pkg::CAUSE_BUS_ERR;
            port.vector = `TSM_VEC_BUS_ERR;
        end else if (port.pend_parity) begin
            port.cause = tsm_pkg::CAUSE_PARITY;
            port.vector = `TSM_VEC_PARITY;
        end else if (port.pend_stack) begin
            port.cause = tsm_pkg::CAUSE_STACK;
            port.vector = `TSM_VEC_STACK;
        end else if (port.pend_pfail) begin
            port.cause = tsm_pkg::CAUSE_PFAIL;
            port.vector = `TSM_VEC_PFAIL;
        end else if (port.trap_code != `TSM_CODE_NONE) begin
            port.cause = tsm_pkg::CAUSE_INSTR;
            // Decode of the instruction trap code.
            unique case (port.trap_code)
                `TSM_CODE_HALT: port.vector = `TSM_VEC_HALT;
                `TSM_CODE_TRAP: port.vector = `TSM_VEC_TRAP;
                `TSM_CODE_EMT: port.vector = `TSM_VEC_EMT;
                `TSM_CODE_IOT: port.vector = `TSM_VEC_IOT;
                `TSM_CODE_BPT: port.vector = `TSM_VEC_BPT;
                `TSM_CODE_ILL: port.vector = `TSM_VEC_ILLEGAL;
                `TSM_CODE_RSV: port.vector = `TSM_VEC_ILLEGAL;
                default: port.vector = 16'h0000;
            endcase
        end else if (port.pend_trace) begin
            port.cause = tsm_pkg::CAUSE_TRACE;
            port.vector = `TSM_VEC_TRACE;
        end else if (port.pend_intr) begin
            port.cause = tsm_pkg::CAUSE_INTR;
            port.vector = port.intr_vector;
        end else begin
            port.take = 1'b0;
        end
    end

    // Any granted cause other than an interrupt blocks bus grants.
    assign port.inhibit_bg = port.take && (port.cause != tsm_pkg::CAUSE_INTR);
endmodule

// ---- rtl/tsm_cstore.sv ----
`timescale 1ns/1ps
module tsm_cstore #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    // =================================================================
    // Storage array; read data come out of a register.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_r;
    logic [WIDTH-1:0] rdata_nxt;

    // Next read word is the addressed location.
    always_comb begin
        rdata_nxt = mem[raddr];
    end

    // Register the read word and perform writes.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = rdata_r;
endmodule

// ---- rtl/tsm_pkg.sv ----
package tsm_pkg;

    // =================================================================
    // Cause of the service currently granted, highest priority first.
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_BUS_ERR = 3'b001,
        CAUSE_PARITY = 3'b010,
        CAUSE_STACK = 3'b011,
        CAUSE_PFAIL = 3'b100,
        CAUSE_INSTR = 3'b101,
        CAUSE_TRACE = 3'b110,
        CAUSE_INTR = 3'b111
    } tsm_cause_e;

    typedef logic [15:0] tsm_vector_t;

endpackage

// ---- rtl/tsm_regs.svh ----
// Summary of operation
// - Trap code is three binary lines; all ones means no instruction trap.
// - Codes: halt 000, trap 001, emulator 010, input/output 011, breakpoint 100.
// - Service microstep with a trap pending forces next-address bit zero.
// - Service step produces the trap vector and selects it for the B register.
// - Service step clears the trace, stack-overflow or power-fail flag it served.
// - Instruction traps flush the instruction register with a clock-timed clear.
// - Bus interrupt branches only when nothing higher pends; device vector used.
// - While a higher trap pends, bus interrupt grants are inhibited.
// - Vector 004 octal for bus errors, 114 octal for memory parity.
// - Vector 010 illegal or reserved, 014 breakpoint, 020 input/output trap.
// - Vector 024 power failure, 030 emulator trap, 034 trap instruction.
// - Control store holds 256 words of 30 bits, addressed by eight bits.
// - Each word carries its successor address, loaded into micro_pc per step.
// - Branch bits other than the power-up bit are OR-ed onto the next address only when the word enables them.
// - A decode request ORs instruction decoder bits onto the next address.
// - Byte branch modifies the next address for even or odd byte operations.
// - Byte branch adds 2 for an even byte and 3 for an odd byte.
// - Initialize clears micro_pc; power-up flop then sets bit zero for address 001.
// - A one-bit control-store field marks the service microstate.
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// =====================================================================
// Trap code encodings.
`define TSM_CODE_HALT 3'h0
`define TSM_CODE_TRAP 3'h1
`define TSM_CODE_EMT 3'h2
`define TSM_CODE_IOT 3'h3
`define TSM_CODE_BPT 3'h4
`define TSM_CODE_ILL 3'h5
`define TSM_CODE_RSV 3'h6
`define TSM_CODE_NONE 3'h7

// =====================================================================
// Trap vectors (hexadecimal byte values).
`define TSM_VEC_BUS_ERR 16'h0004
`define TSM_VEC_ILLEGAL 16'h0008
`define TSM_VEC_BPT 16'h000c
`define TSM_VEC_IOT 16'h0010
`define TSM_VEC_PFAIL 16'h0014
`define TSM_VEC_EMT 16'h0018
`define TSM_VEC_TRAP 16'h001c
`define TSM_VEC_PARITY 16'h004c
`define TSM_VEC_HALT 16'h0000
`define TSM_VEC_TRACE 16'h000c
`define TSM_VEC_STACK 16'h0004

// =====================================================================
// Control word field positions.
`define TSM_F_NEXT_MSB 7
`define TSM_F_NEXT_LSB 0
`define TSM_F_BYTE 8
`define TSM_F_SERVICE 9
`define TSM_F_DECODE 10

// =====================================================================
// Sequencer constants.
`define TSM_CS_WIDTH 30
`define TSM_CS_DEPTH 256
`define TSM_CS_AW 8
`define TSM_BYTE_EVEN_INC 8'h02
`define TSM_BYTE_ODD_INC 8'h03
`define TSM_PC_RESET 8'h00

// =====================================================================
// Register byte offsets and reset values.
`define TSM_OFS_CTRL 8'h00
`define TSM_OFS_CS_ADDR 8'h04
`define TSM_OFS_CS_DATA 8'h08
`define TSM_OFS_STATUS 8'h0c
`define TSM_OFS_VECTOR 8'h10
`define TSM_CTRL_RUN_BIT 0
`define TSM_CTRL_INIT_BIT 1
`define TSM_RST_RUN 1'b0
`define TSM_RST_CS_ADDR 8'h00

`endif

// ---- rtl/tsm_trap_sequencer.sv ----
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_trap_sequencer (
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Datapath and decoder side.
    input wire logic init,
    input wire logic [2:0] trap_code,
    input wire logic bus_error_flag,
    input wire logic parity_error_flag,
    input wire logic stack_ovf_flag,
    input wire logic power_fail_flag,
    input wire logic trace_flag,
    input wire logic bus_intr,
    input wire logic [15:0] intr_vector,
    input wire logic [7:0] decode_bits,
    input wire logic byte_op,
    input wire logic byte_odd,
    // Sequencer and service outputs.
    output logic ustep_strobe,
    output logic [7:0] micro_pc,
    output logic [29:0] ctrl_word,
    output logic a_mux_select0,
    output logic [15:0] service_vector,
    output logic trace_clear,
    output logic stack_ovf_clear,
    output logic power_fail_clear,
    output logic bus_error_clear,
    output logic parity_clear,
    output logic instr_trap_clear,
    output logic ir_flush,
    output logic bg_inhibit
);
    // ====================
    // Bus slave state.
    logic dp_wr_r;
    logic dp_wr_nxt;
    logic [7:0] dp_addr_r;
    logic [7:0] dp_addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic hreadyout_r;
    logic hresp_r;
    logic run_r;
    logic run_nxt;
    logic init_req_r;
    logic init_req_nxt;
    logic [7:0] cs_addr_r;
    logic [7:0] cs_addr_nxt;
    logic cs_we;
    logic addr_phase;
    logic [31:0] rd_mux;

    // ====================
    // Sequencer state.
    logic [7:0] micro_pc_r;
    logic [7:0] micro_pc_nxt;
    logic pwr_up_r;
    logic pwr_up_nxt;
    logic word_ok_r;
    logic word_ok_nxt;
    logic [7:0] cs_raddr;
    logic [29:0] cs_word;
    logic [7:0] next_addr;
    logic [7:0] byte_addr;
    logic service_now;
    logic take_now;
    logic step;
    logic init_any;
    logic served;
    tsm_pkg::tsm_cause_e last_cause_r;
    tsm_pkg::tsm_cause_e last_cause_nxt;
    logic [15:0] last_vec_r;
    logic [15:0] last_vec_nxt;

    // ====================
    // Output stage state, aligned with the microstep it reports.
    logic ustep_r;
    logic [7:0] out_pc_r;
    logic [7:0] out_pc_nxt;
    logic [29:0] ctrl_word_r;
    logic [29:0] ctrl_word_nxt;
    logic a_sel0_r;
    logic a_sel0_nxt;
    logic [15:0] svc_vec_r;
    logic [15:0] svc_vec_nxt;
    logic trace_clr_r;
    logic stack_clr_r;
    logic pfail_clr_r;
    logic berr_clr_r;
    logic par_clr_r;
    logic itrap_clr_r;
    logic ir_flush_r;
    logic bg_inh_r;

    tsm_arb_if u_arb_if ();

    // ====================
    // Trap arbitration.
    tsm_arbiter u_arbiter (
        .port(u_arb_if)
    );

    // Pending conditions feed the arbiter every cycle.
    assign u_arb_if.pend_bus_err = bus_error_flag;
    assign u_arb_if.pend_parity = parity_error_flag;
    assign u_arb_if.pend_stack = stack_ovf_flag;
    assign u_arb_if.pend_pfail = power_fail_flag;
    assign u_arb_if.pend_trace = trace_flag;
    assign u_arb_if.pend_intr = bus_intr;
    assign u_arb_if.trap_code = trap_code;
    assign u_arb_if.intr_vector = intr_vector;

    // ====================
    // Control store: written over the bus, read at the next address.
    tsm_cstore #(
        .WIDTH(`TSM_CS_WIDTH),
        .DEPTH(`TSM_CS_DEPTH),
        .AW(`TSM_CS_AW)
    ) u_cstore (
        .clk(clk),
        .rst(rst),
        .we(cs_we),
        .waddr(cs_addr_r),
        .wdata(hwdata[29:0]),
        .raddr(cs_raddr),
        .rdata(cs_word)
    );

    // ====================
    // Bus slave: zero wait states, reads answered in the data phase.
    assign addr_phase = hsel && htrans[1] && hready;
    assign cs_we = dp_wr_r && (dp_addr_r == `TSM_OFS_CS_DATA);

    // Read multiplexer over the register map; unmapped reads give zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            `TSM_OFS_CTRL: rd_mux = {31'h0000_0000, run_r};
            `TSM_OFS_CS_ADDR: rd_mux = {24'h00_0000, cs_addr_r};
            `TSM_OFS_STATUS: rd_mux = {19'h0_0000, pwr_up_r, bg_inh_r,
                                       last_cause_r, micro_pc_r};
            `TSM_OFS_VECTOR: rd_mux = {16'h0000, last_vec_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Next values of the bus and register state.
    always_comb begin
        dp_wr_nxt = 1'b0;
        dp_addr_nxt = dp_addr_r;
        hrdata_nxt = hrdata_r;
        run_nxt = run_r;
        init_req_nxt = 1'b0;
        cs_addr_nxt = cs_addr_r;
        if (addr_phase) begin
            dp_wr_nxt = hwrite;
            dp_addr_nxt = haddr[7:0];
            hrdata_nxt = hwrite ? 32'h0000_0000 : rd_mux;
        end
        if (dp_wr_r) begin
            unique case (dp_addr_r)
                `TSM_OFS_CTRL: begin
                    run_nxt = hwdata[`TSM_CTRL_RUN_BIT];
                    init_req_nxt = hwdata[`TSM_CTRL_INIT_BIT];
                end
                `TSM_OFS_CS_ADDR: cs_addr_nxt = hwdata[7:0];
                `TSM_OFS_CS_DATA: cs_addr_nxt = cs_addr_r + 8'h01;
                default: cs_addr_nxt = cs_addr_r;
            endcase
        end
    end

    // Register the bus and register state.
    always_ff @(posedge clk) begin
        if (rst) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            run_r <= `TSM_RST_RUN;
            init_req_r <= 1'b0;
            cs_addr_r <= `TSM_RST_CS_ADDR;
        end else begin
            dp_wr_r <= dp_wr_nxt;
            dp_addr_r <= dp_addr_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            run_r <= run_nxt;
            init_req_r <= init_req_nxt;
            cs_addr_r <= cs_addr_nxt;
        end
    end

    // ====================
    // Next-address formation.
    assign init_any = init || init_req_r;
    assign step = run_r && word_ok_r && !init_any;
    assign service_now = cs_word[`TSM_F_SERVICE];
    assign take_now = service_now && u_arb_if.take;
    assign served = step && take_now;

    // Byte branch offsets the successor for byte instructions.
    always_comb begin
        byte_addr = cs_word[`TSM_F_NEXT_MSB:`TSM_F_NEXT_LSB];
        if (cs_word[`TSM_F_BYTE] && byte_op) begin
            byte_addr = byte_addr + (byte_odd ? `TSM_BYTE_ODD_INC
                                               : `TSM_BYTE_EVEN_INC);
        end
    end

    // Wire-OR sources other than the power-up flop are added only when the word enables them.
    always_comb begin
        next_addr = byte_addr;
        if (cs_word[`TSM_F_DECODE]) begin
            next_addr = next_addr | decode_bits;
        end
        if (take_now) begin
            next_addr[0] = 1'b1;
        end
        if (pwr_up_r) begin
            next_addr[0] = 1'b1;
        end
    end

    // The store reads ahead at the successor so its word is ready next cycle.
    assign cs_raddr = step ? next_addr : micro_pc_r;

    // Next values of the sequencer state.
    always_comb begin
        micro_pc_nxt = micro_pc_r;
        pwr_up_nxt = pwr_up_r;
        word_ok_nxt = !cs_we;
        last_cause_nxt = last_cause_r;
        last_vec_nxt = last_vec_r;
        if (init_any) begin
            micro_pc_nxt = `TSM_PC_RESET;
            pwr_up_nxt = 1'b1;
            word_ok_nxt = 1'b0;
        end else if (step) begin
            micro_pc_nxt = next_addr;
            pwr_up_nxt = 1'b0;
            if (take_now) begin
                last_cause_nxt = u_arb_if.cause;
                last_vec_nxt = u_arb_if.vector;
            end
        end
    end

    // Register the sequencer state.
    always_ff @(posedge clk) begin
        if (rst) begin
            micro_pc_r <= `TSM_PC_RESET;
            pwr_up_r <= 1'b1;
            word_ok_r <= 1'b0;
            last_cause_r <= tsm_pkg::CAUSE_NONE;
            last_vec_r <= 16'h0000;
        end else begin
            micro_pc_r <= micro_pc_nxt;
            pwr_up_r <= pwr_up_nxt;
            word_ok_r <= word_ok_nxt;
            last_cause_r <= last_cause_nxt;
            last_vec_r <= last_vec_nxt;
        end
    end

    // ====================
    // Output stage: word, vector and clears of one microstep together.
    always_comb begin
        out_pc_nxt = out_pc_r;
        ctrl_word_nxt = ctrl_word_r;
        a_sel0_nxt = 1'b0;
        svc_vec_nxt = svc_vec_r;
        if (step) begin
            out_pc_nxt = micro_pc_r;
            ctrl_word_nxt = cs_word;
            a_sel0_nxt = take_now;
            svc_vec_nxt = take_now ? u_arb_if.vector : 16'h0000;
        end
    end

    // Register the outputs; clear strobes last one cycle per service step.
    always_ff @(posedge clk) begin
        if (rst) begin
            ustep_r <= 1'b0;
            out_pc_r <= `TSM_PC_RESET;
            ctrl_word_r <= '0;
            a_sel0_r <= 1'b0;
            svc_vec_r <= 16'h0000;
            trace_clr_r <= 1'b0;
            stack_clr_r <= 1'b0;
            pfail_clr_r <= 1'b0;
            berr_clr_r <= 1'b0;
            par_clr_r <= 1'b0;
            itrap_clr_r <= 1'b0;
            ir_flush_r <= 1'b0;
            bg_inh_r <= 1'b0;
        end else begin
            ustep_r <= step;
            out_pc_r <= out_pc_nxt;
            ctrl_word_r <= ctrl_word_nxt;
            a_sel0_r <= a_sel0_nxt;
            svc_vec_r <= svc_vec_nxt;
            trace_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_TRACE);
            stack_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_STACK);
            pfail_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_PFAIL);
            berr_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_BUS_ERR);
            par_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_PARITY);
            itrap_clr_r <= served && (u_arb_if.cause == tsm_pkg::CAUSE_INSTR);
            // Flush follows the clear by one clock, standing in for clock gating.
            ir_flush_r <= itrap_clr_r;
            bg_inh_r <= u_arb_if.inhibit_bg;
        end
    end

    // Every output is a flip-flop.
    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign ustep_strobe = ustep_r;
    assign micro_pc = out_pc_r;
    assign ctrl_word = ctrl_word_r;
    assign a_mux_select0 = a_sel0_r;
    assign service_vector = svc_vec_r;
    assign trace_clear = trace_clr_r;
    assign stack_ovf_clear = stack_clr_r;
    assign power_fail_clear = pfail_clr_r;
    assign bus_error_clear = berr_clr_r;
    assign parity_clear = par_clr_r;
    assign instr_trap_clear = itrap_clr_r;
    assign ir_flush = ir_flush_r;
    assign bg_inhibit = bg_inh_r;
endmodule
